// File: src/dpgpio_top.sv
// Dual port GPIO with change and external interrupts behind a plain register port
`include "dpgpio_defs.svh"
// Function
// - First port has six pins; direction one is input, zero drives latch.
// - Port data reads return pin levels; writes update the output latch.
// - Port writes merge written bits with sampled pins into the latch.
// - First port bit 4 is timer clock input and drives only low.
// - Analog config selects analog pins; after reset all but bit 4 analog, reading zero.
// - Direction bits still steer analog pins; software keeps them set.
// - Upper two first port direction bits unimplemented, read zero.
// - Second port has eight pins with per-bit direction control.
// - Option bit 7 low enables weak pull-ups on second port.
// - Pull-up switches off whenever its pin is an output.
// - Reset leaves all second port pull-ups disabled.
// - Only upper four second port inputs take part in change detection.
// - Inputs compared with value latched on last read or write; mismatch sets flag.
// - Port change interrupt can wake the device from sleep.
// - Mismatch keeps setting flag; read or write ends it, then clear.
// - Second port bit 0 is external interrupt; edge chosen by option bit 6.
module dpgpio_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire dpgpio_pkg::dpgpio_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output dpgpio_pkg::dpgpio_byte_t reg_rdata,
    // First port pins
    input wire dpgpio_pkg::dpgpio_first_port_data_t first_port_data_in,
    output dpgpio_pkg::dpgpio_first_port_data_t first_port_data_out,
    output dpgpio_pkg::dpgpio_first_port_data_t first_port_data_oe_n,
    output logic timer_clock_in,
    output dpgpio_pkg::dpgpio_acfg_t analog_config_field,
    // Second port pins
    input wire dpgpio_pkg::dpgpio_byte_t second_port_data_in,
    output dpgpio_pkg::dpgpio_byte_t second_port_data_out,
    output dpgpio_pkg::dpgpio_byte_t second_port_data_oe_n,
    output dpgpio_pkg::dpgpio_byte_t second_port_data_pullup_en,
    // Interrupt and wake
    output logic irq,
    output logic wake
);
    import dpgpio_pkg::*;

    dpgpio_first_port_data_t pa_meta_q, pa_sync_q, pa_latch_q, pa_dir_q;
    dpgpio_byte_t pb_meta_q, pb_sync_q, pb_latch_q, pb_dir_q, option_q;
    dpgpio_acfg_t acfg_q;
    logic [3:0] pb_last_q;
    logic pb_int_prev_q;
    logic change_flag_q, ext_flag_q;
    dpgpio_irq_t irq_stat_q, irq_mask_q;
    dpgpio_byte_t rdata_d;
    dpgpio_first_port_data_t pa_analog, pa_read;
    logic [3:0] mismatch;
    logic change_evt, ext_evt, ext_rise, ext_fall;
    logic wr_pa, wr_pb, rd_pb, wr_ic, wr_st;
    dpgpio_irq_t evt_vec;

    assign wr_pa = reg_wr && reg_addr == `DPG_OFF_FIRST_PORT_DATA_PINS;
    assign wr_pb = reg_wr && reg_addr == `DPG_OFF_SECOND_PORT_DATA_DATA;
    assign rd_pb = reg_rd && reg_addr == `DPG_OFF_SECOND_PORT_DATA_DATA;
    assign wr_ic = reg_wr && reg_addr == `DPG_OFF_INT_CTRL;
    assign wr_st = reg_wr && reg_addr == `DPG_OFF_IRQ_STATUS;

    // Two-flop pin synchronisers; only the second stage is used anywhere
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_meta_q <= 6'h00;
            pa_sync_q <= 6'h00;
            pb_meta_q <= 8'h00;
            pb_sync_q <= 8'h00;
        end else begin
            pa_meta_q <= first_port_data_in;
            pa_sync_q <= pa_meta_q;
            pb_meta_q <= second_port_data_in;
            pb_sync_q <= pb_meta_q;
        end
    end

    // Analog pins per configuration code; codes 110 and 111 make all digital
    always_comb begin
        unique case (acfg_q)
            3'h0, 3'h1: pa_analog = 6'h2f;
            3'h2, 3'h3: pa_analog = 6'h2f;
            3'h4: pa_analog = 6'h0b;
            3'h5: pa_analog = 6'h03;
            default: pa_analog = 6'h00;
        endcase
    end
    // Analog pins read as zero in the digital path
    assign pa_read = pa_sync_q & ~pa_analog;

    // Control registers; direction resets to inputs, pull-ups off
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_dir_q <= `DPG_FIRST_PORT_DATA_DIR_RST;
            pb_dir_q <= `DPG_SECOND_PORT_DATA_DIR_RST;
            option_q <= `DPG_OPTION_RST;
            acfg_q <= `DPG_ANALOG_CFG_RST;
            irq_mask_q <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `DPG_OFF_FIRST_PORT_DATA_DIR: pa_dir_q <= reg_wdata[5:0];
                `DPG_OFF_SECOND_PORT_DATA_DIR: pb_dir_q <= reg_wdata;
                `DPG_OFF_OPTION: option_q <= reg_wdata;
                `DPG_OFF_ANALOG_CFG: acfg_q <= reg_wdata[2:0];
                `DPG_OFF_IRQ_MASK: irq_mask_q <= reg_wdata[`DPG_IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Output latches; a write is read-modify-write over the sampled pins, so
    // a latch bit of an input pin picks up the pin level (zero for an analog first port pin), as documented
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_latch_q <= 6'h00;
            pb_latch_q <= 8'h00;
        end else begin
            if (wr_pa) begin
                pa_latch_q <= (reg_wdata[5:0] & ~pa_dir_q) | (pa_read & pa_dir_q);
            end
            if (wr_pb) begin
                pb_latch_q <= (reg_wdata & ~pb_dir_q) | (pb_sync_q & pb_dir_q);
            end
        end
    end

    // Change detection against value captured on last access of second port
    assign mismatch = (pb_sync_q[7:4] ^ pb_last_q) & pb_dir_q[7:4];
    assign change_evt = |mismatch;
    assign ext_rise = pb_sync_q[0] && !pb_int_prev_q;
    assign ext_fall = !pb_sync_q[0] && pb_int_prev_q;
    assign ext_evt = option_q[`DPG_OPT_EDGE_BIT] ? ext_rise : ext_fall;

    // Compare latch and edge history; a read or write of the second port data ends the mismatch
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pb_last_q <= 4'h0;
            pb_int_prev_q <= 1'b0;
        end else begin
            pb_int_prev_q <= pb_sync_q[0];
            if (rd_pb || wr_pb) begin
                pb_last_q <= pb_sync_q[7:4];
            end
        end
    end

    // Flags: the hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            change_flag_q <= 1'b0;
            ext_flag_q <= 1'b0;
        end else begin
            if (change_evt) begin
                change_flag_q <= 1'b1;
            end else if (wr_ic && !reg_wdata[`DPG_CHANGE_FLAG_BIT]) begin
                change_flag_q <= 1'b0;
            end
            if (ext_evt) begin
                ext_flag_q <= 1'b1;
            end else if (wr_ic && !reg_wdata[`DPG_EXT_FLAG_BIT]) begin
                ext_flag_q <= 1'b0;
            end
        end
    end

    // Sticky status, write one to clear, set wins
    assign evt_vec = {ext_evt, change_evt};
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= evt_vec | (irq_stat_q & ~(wr_st ? reg_wdata[`DPG_IRQ_BITS-1:0] : '0));
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        unique case (reg_addr)
            `DPG_OFF_FIRST_PORT_DATA_PINS: rdata_d = {2'b00, pa_read};
            `DPG_OFF_SECOND_PORT_DATA_DATA: rdata_d = pb_sync_q;
            `DPG_OFF_FIRST_PORT_DATA_DIR: rdata_d = {2'b00, pa_dir_q};
            `DPG_OFF_SECOND_PORT_DATA_DIR: rdata_d = pb_dir_q;
            `DPG_OFF_OPTION: rdata_d = option_q;
            `DPG_OFF_ANALOG_CFG: rdata_d = {5'h00, acfg_q};
            `DPG_OFF_INT_CTRL: rdata_d = {6'h00, ext_flag_q, change_flag_q};
            `DPG_OFF_IRQ_STATUS: rdata_d = {6'h00, irq_stat_q};
            `DPG_OFF_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // Registered outputs: read data, pin drives, pull-ups, interrupt
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            first_port_data_out <= 6'h00;
            first_port_data_oe_n <= 6'h3f;
            second_port_data_out <= 8'h00;
            second_port_data_oe_n <= 8'hff;
            second_port_data_pullup_en <= 8'h00;
            timer_clock_in <= 1'b0;
            analog_config_field <= 3'h0;
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
            first_port_data_out <= pa_latch_q;
            // Open-drain bit 4 enables its driver only to pull low
            first_port_data_oe_n <= pa_dir_q | (pa_latch_q & 6'h10);
            second_port_data_out <= pb_latch_q;
            second_port_data_oe_n <= pb_dir_q;
            second_port_data_pullup_en <= option_q[`DPG_OPT_PULLUP_BIT] ? 8'h00 : pb_dir_q;
            timer_clock_in <= pa_sync_q[`DPG_TIMER_PIN_BIT];
            analog_config_field <= acfg_q;
            irq <= |((irq_stat_q | evt_vec) & irq_mask_q);
            // Wake is raised by the change flag regardless of mask
            wake <= change_flag_q | change_evt;
        end
    end

    a_pullup_off_output: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (pb_dir_q == 8'h00) |=> (second_port_data_pullup_en == 8'h00))
        else $error("pull-up active on output pin");
    a_pullup_ctrl: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!option_q[7] && pb_dir_q == 8'hff) |=> (second_port_data_pullup_en == 8'hff))
        else $error("pull-ups not enabled");
    a_open_drain_high: assert property (@(posedge ref_clk) disable iff (!arst_n)
        first_port_data_oe_n[4] == 1'b0 |-> first_port_data_out[4] == 1'b0)
        else $error("open-drain pin driven high");
    a_dir_hidden: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == 8'h85) |=> reg_rdata[7:6] == 2'b00)
        else $error("upper direction bits nonzero");
    a_change_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (|((pb_sync_q[7:4] ^ pb_last_q) & pb_dir_q[7:4])) |=> change_flag_q)
        else $error("change flag not set");
    a_output_excluded: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (pb_dir_q[7:4] == 4'h0) |-> !change_evt)
        else $error("output pin in change compare");
    a_access_relatch: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (rd_pb || wr_pb) |=> pb_last_q == $past(pb_sync_q[7:4]))
        else $error("compare value not relatched");
    a_ext_edge: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (option_q[6] && pb_sync_q[0] && !pb_int_prev_q) |=> ext_flag_q)
        else $error("external edge missed");
    a_port_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == 8'h06) |=> reg_rdata == $past(pb_sync_q))
        else $error("port read wrong");
    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ##2 pb_sync_q == $past(second_port_data_in, 2))
        else $error("sync depth wrong");
    a_wake_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        change_flag_q |=> wake)
        else $error("no wake on change");


    // Read data stand for one cycle only, zero otherwise
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");

    // First port upper bits do not exist
    a_first_port_data_upper_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == 8'h05) |=> reg_rdata[7:6] == 2'b00)
        else $error("first port upper bits nonzero");

    // After reset every pin but bit 4 is analog and reads zero
    a_analog_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == 8'h05 && acfg_q == 3'h0) |=> reg_rdata[5:0] == 6'h10)
        else $error("analog pin read nonzero");

    // Pin drive follows the latch one cycle later
    a_first_port_data_out_latch: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> first_port_data_out == $past(pa_latch_q))
        else $error("first port drive off latch");

    // All inputs means no driver enabled
    a_first_port_data_all_inputs: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (pa_dir_q == 6'h3f) |=> first_port_data_oe_n == 6'h3f)
        else $error("first port input driven");

    // Open-drain pin releases when its latch is high
    a_open_drain_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pa_latch_q[4] |=> first_port_data_oe_n[4])
        else $error("open-drain pin not released");

    // Timer sees the synchronised shared pin
    a_timer_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> timer_clock_in == $past(pa_sync_q[4]))
        else $error("timer input stale");

    // Configuration copy follows the register
    a_cfg_copy: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> analog_config_field == $past(acfg_q))
        else $error("analog config copy stale");

    // Second port drivers follow direction
    a_second_port_data_oe_dir: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> second_port_data_oe_n == $past(pb_dir_q))
        else $error("second port enable off direction");

    // Second port drive follows the latch
    a_second_port_data_out_latch: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> second_port_data_out == $past(pb_latch_q))
        else $error("second port drive off latch");

    // Disable bit high keeps every pull-up off
    a_pullup_disabled: assert property (@(posedge ref_clk) disable iff (!arst_n)
        option_q[7] |=> second_port_data_pullup_en == 8'h00)
        else $error("pull-up on while disabled");

    // No pull-up on any pin that drives
    a_pullup_inputs_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> (second_port_data_pullup_en & ~$past(pb_dir_q)) == 8'h00)
        else $error("pull-up on driven pin");

    // Written bits of output pins land in the latch
    a_write_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_pa |=> ((pa_latch_q ^ $past(reg_wdata[5:0])) & ~$past(pa_dir_q)) == 6'h00)
        else $error("first port write lost");

    // Same for the second port
    a_write_out_b: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_pb |=> ((pb_latch_q ^ $past(reg_wdata)) & ~$past(pb_dir_q)) == 8'h00)
        else $error("second port write lost");

    // Input pin bits take the sampled pin level on write
    a_rmw_inputs: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_pb |=> ((pb_latch_q ^ $past(pb_sync_q)) & $past(pb_dir_q)) == 8'h00)
        else $error("merge of pin levels wrong");

    // Compare value holds between accesses
    a_relatch_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(rd_pb || wr_pb) |=> pb_last_q == $past(pb_last_q))
        else $error("compare value moved");

    // No change and no flag means the flag stays clear
    a_change_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!change_flag_q && !change_evt) |=> !change_flag_q)
        else $error("spurious change flag");

    // Clear works once the mismatch has ended
    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (wr_ic && !reg_wdata[0] && !change_evt) |=> !change_flag_q)
        else $error("change flag not cleared");

    // Falling edge selected catches a fall
    a_ext_fall: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!option_q[6] && !pb_sync_q[0] && pb_int_prev_q) |=> ext_flag_q)
        else $error("falling edge missed");

    // A steady pin never raises the external flag
    a_ext_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!ext_flag_q && pb_sync_q[0] == pb_int_prev_q) |=> !ext_flag_q)
        else $error("spurious external flag");

    // Status bit stays until written one
    a_status_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (irq_stat_q[0] && !wr_st) |=> irq_stat_q[0])
        else $error("status bit lost");

    // Fully masked means no interrupt
    a_irq_masked: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (irq_mask_q == '0) |=> !irq)
        else $error("masked interrupt raised");

    // No change pending means no wake
    a_wake_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!change_flag_q && !change_evt) |=> !wake)
        else $error("spurious wake");

    c_change: cover property (@(posedge ref_clk) disable iff (!arst_n) change_evt ##1 rd_pb);
    c_ext: cover property (@(posedge ref_clk) disable iff (!arst_n) ext_evt);
    c_irq: cover property (@(posedge ref_clk) disable iff (!arst_n) irq);
    c_rmw: cover property (@(posedge ref_clk) disable iff (!arst_n) wr_pa && pa_dir_q != 6'h3f);
endmodule

// File: src/dpgpio_defs.svh
// Register offsets, field positions, reset values and counts for the dual port GPIO block
`ifndef DPGPIO_DEFS_SVH
`define DPGPIO_DEFS_SVH
`define DPG_OFF_FIRST_PORT_DATA_PINS 8'h05
`define DPG_OFF_SECOND_PORT_DATA_DATA 8'h06
`define DPG_OFF_OPTION 8'h81
`define DPG_OFF_FIRST_PORT_DATA_DIR 8'h85
`define DPG_OFF_SECOND_PORT_DATA_DIR 8'h86
`define DPG_OFF_ANALOG_CFG 8'h9f
`define DPG_OFF_INT_CTRL 8'h0b
`define DPG_OFF_IRQ_STATUS 8'hc0
`define DPG_OFF_IRQ_MASK 8'hc1
`define DPG_FIRST_PORT_DATA_DIR_RST 6'h3f
`define DPG_SECOND_PORT_DATA_DIR_RST 8'hff
`define DPG_OPTION_RST 8'hff
`define DPG_ANALOG_CFG_RST 3'h0
`define DPG_OPT_PULLUP_BIT 7
`define DPG_OPT_EDGE_BIT 6
`define DPG_CHANGE_FLAG_BIT 0
`define DPG_EXT_FLAG_BIT 1
`define DPG_TIMER_PIN_BIT 4
`define DPG_IRQ_BITS 2
`endif

// File: src/dpgpio_pkg.sv
// Types shared by the dual port GPIO block
`include "dpgpio_defs.svh"
package dpgpio_pkg;
    typedef logic [7:0] dpgpio_byte_t;
    typedef logic [5:0] dpgpio_first_port_data_t;
    typedef logic [2:0] dpgpio_acfg_t;
    typedef logic [`DPG_IRQ_BITS-1:0] dpgpio_irq_t;
endpackage

// File: testbench/dpgpio_pins.sv
// Pin model: far side drivers, open-drain timer pin, pull-ups, floating lines
module dpgpio_pins (
    // Clock
    input wire logic ref_clk,
    // Device drive
    input wire dpgpio_pkg::dpgpio_first_port_data_t first_port_data_out,
    input wire dpgpio_pkg::dpgpio_first_port_data_t first_port_data_oe_n,
    input wire dpgpio_pkg::dpgpio_byte_t second_port_data_out,
    input wire dpgpio_pkg::dpgpio_byte_t second_port_data_oe_n,
    input wire dpgpio_pkg::dpgpio_byte_t second_port_data_pullup_en,
    // Far side drive, per-bit enable on the second port
    input wire dpgpio_pkg::dpgpio_first_port_data_t ext_a,
    input wire dpgpio_pkg::dpgpio_byte_t ext_b,
    input wire dpgpio_pkg::dpgpio_byte_t ext_b_en,
    // Resolved pin levels
    output dpgpio_pkg::dpgpio_first_port_data_t first_port_data_in,
    output dpgpio_pkg::dpgpio_byte_t second_port_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import dpgpio_pkg::*;
    logic flip_q;
    // A floating line wanders, so a stale level can never pass for a drive
    always_ff @(posedge ref_clk) begin
        flip_q <= (flip_q !== 1'b1);
    end
    // Enabled drivers win; bit 4 can only pull low
    always_comb begin
        first_port_data_in = (first_port_data_oe_n & ext_a) | (~first_port_data_oe_n & first_port_data_out);
        first_port_data_in[4] = first_port_data_oe_n[4] ? ext_a[4] : 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (!second_port_data_oe_n[i]) begin
                second_port_data_in[i] = second_port_data_out[i];
            end else if (ext_b_en[i]) begin
                second_port_data_in[i] = ext_b[i];
            end else begin
                second_port_data_in[i] = second_port_data_pullup_en[i] ? 1'b1 : flip_q;
            end
        end
    end
endmodule

// File: testbench/dpgpio_top_bench.sv
// Register-level bench for the dual port GPIO block with a pin model
`include "dpgpio_defs.svh"
module dpgpio_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dpgpio_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    dpgpio_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    dpgpio_byte_t reg_rdata, second_port_data_in, second_port_data_out, second_port_data_oe_n, second_port_data_pullup_en;
    dpgpio_first_port_data_t first_port_data_in, first_port_data_out, first_port_data_oe_n;
    dpgpio_acfg_t analog_config_field;
    logic timer_clock_in, irq, wake;
    dpgpio_first_port_data_t ext_a = 6'h3f;
    dpgpio_byte_t ext_b = 8'h00;
    dpgpio_byte_t ext_b_en = 8'hff;
    int err_total = 0;
    int compares = 0;
    // Device and pins
    dpgpio_top u_dpgpio_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_port_data_in(first_port_data_in), .first_port_data_out(first_port_data_out), .first_port_data_oe_n(first_port_data_oe_n),
        .timer_clock_in(timer_clock_in), .analog_config_field(analog_config_field),
        .second_port_data_in(second_port_data_in), .second_port_data_out(second_port_data_out), .second_port_data_oe_n(second_port_data_oe_n),
        .second_port_data_pullup_en(second_port_data_pullup_en), .irq(irq), .wake(wake));
    dpgpio_pins u_dpgpio_pins (.ref_clk(ref_clk), .first_port_data_out(first_port_data_out),
        .first_port_data_oe_n(first_port_data_oe_n), .second_port_data_out(second_port_data_out), .second_port_data_oe_n(second_port_data_oe_n),
        .second_port_data_pullup_en(second_port_data_pullup_en), .ext_a(ext_a), .ext_b(ext_b),
        .ext_b_en(ext_b_en), .first_port_data_in(first_port_data_in), .second_port_data_in(second_port_data_in));
    // 20 MHz core clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One-cycle strobes; read data are taken in the cycle after the read edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Bounded wait on the interrupt line; running out ends the run
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 10) begin
            idle(1);
            n++;
        end
        chk({7'h00, irq}, 8'h01);
        if (irq !== 1'b1) begin
            wrap_up();
        end
    endtask
    // Main sequence
    initial begin
        idle(20);
        arst_n <= 1'b1;
        idle(4);
        chk(second_port_data_pullup_en, 8'h00);
        rd(`DPG_OFF_FIRST_PORT_DATA_DIR, 8'h3f);
        rd(`DPG_OFF_SECOND_PORT_DATA_DIR, 8'hff);
        rd(8'h10, 8'h00);
        rd(`DPG_OFF_FIRST_PORT_DATA_PINS, 8'h10);
        wr(`DPG_OFF_ANALOG_CFG, 8'h06);
        rd(`DPG_OFF_ANALOG_CFG, 8'h06);
        rd(`DPG_OFF_FIRST_PORT_DATA_PINS, 8'h3f);
        ext_a <= 6'h2a;
        idle(4);
        wr(`DPG_OFF_FIRST_PORT_DATA_PINS, 8'h00);
        wr(`DPG_OFF_FIRST_PORT_DATA_DIR, 8'h00);
        idle(3);
        chk({2'b00, first_port_data_out}, 8'h2a);
        chk({2'b00, first_port_data_oe_n}, 8'h00);
        wr(`DPG_OFF_FIRST_PORT_DATA_PINS, 8'h15);
        idle(4);
        chk({2'b00, first_port_data_oe_n}, 8'h10);
        rd(`DPG_OFF_FIRST_PORT_DATA_PINS, 8'h05);
        ext_a <= 6'h10;
        idle(4);
        chk({7'h00, timer_clock_in}, 8'h01);
        wr(`DPG_OFF_FIRST_PORT_DATA_DIR, 8'hff);
        rd(`DPG_OFF_FIRST_PORT_DATA_DIR, 8'h3f);
        // Second port: pull-ups, direction, merged writes
        ext_b_en <= 8'hf7;
        wr(`DPG_OFF_OPTION, 8'h7f);
        idle(4);
        chk(second_port_data_pullup_en, 8'hff);
        rd(`DPG_OFF_SECOND_PORT_DATA_DATA, 8'h08);
        wr(`DPG_OFF_SECOND_PORT_DATA_DIR, 8'hf0);
        wr(`DPG_OFF_SECOND_PORT_DATA_DATA, 8'ha5);
        idle(4);
        chk(second_port_data_pullup_en, 8'hf0);
        chk(second_port_data_oe_n, 8'hf0);
        chk(second_port_data_out, 8'h05);
        // Change detection, masking and clearing
        wr(`DPG_OFF_IRQ_MASK, 8'h03);
        wr(`DPG_OFF_IRQ_STATUS, 8'h03);
        wr(`DPG_OFF_INT_CTRL, 8'h00);
        rd(`DPG_OFF_INT_CTRL, 8'h00);
        ext_b <= 8'h20;
        wait_irq();
        rd(`DPG_OFF_INT_CTRL, 8'h01);
        wr(`DPG_OFF_INT_CTRL, 8'h00);
        rd(`DPG_OFF_INT_CTRL, 8'h01);
        wr(`DPG_OFF_IRQ_MASK, 8'h00);
        idle(2);
        chk({6'h00, irq, wake}, 8'h01);
        rd(`DPG_OFF_SECOND_PORT_DATA_DATA, 8'h25);
        wr(`DPG_OFF_IRQ_STATUS, 8'h03);
        wr(`DPG_OFF_INT_CTRL, 8'h00);
        wr(`DPG_OFF_IRQ_MASK, 8'h03);
        idle(2);
        chk({6'h00, irq, wake}, 8'h00);
        // Lower pins never count as a change; one relatching read only
        wr(`DPG_OFF_SECOND_PORT_DATA_DIR, 8'hff);
        idle(4);
        rd(`DPG_OFF_SECOND_PORT_DATA_DATA, 8'h28);
        wr(`DPG_OFF_IRQ_STATUS, 8'h03);
        ext_b <= 8'h2e;
        idle(6);
        rd(`DPG_OFF_IRQ_STATUS, 8'h00);
        // External interrupt on both edge selections
        ext_b <= 8'h2f;
        idle(6);
        rd(`DPG_OFF_IRQ_STATUS, 8'h02);
        wr(`DPG_OFF_OPTION, 8'h3f);
        wr(`DPG_OFF_IRQ_STATUS, 8'h03);
        ext_b <= 8'h2e;
        idle(6);
        rd(`DPG_OFF_IRQ_STATUS, 8'h02);
        wrap_up();
    end
endmodule
